// *** common/hrp_pkg.sv ***
// shared constants for the hardware-response port and its clock blocks
package hrp_pkg;
  localparam int HRP_REF_CLK_MHZ = 100;
  localparam int HRP_CNT_W = 16;
  localparam int HRP_NUM_CB = 6;
  localparam int HRP_CB_DIV_W = 8;
  localparam int HRP_CB_SEL_W = 3;
  localparam int HRP_PORT_W_DEF = 4;
  localparam int HRP_XFER_W_DEF = 32;
  localparam int HRP_BUF_W_DEF = 48;
  localparam logic [2:0] HRP_CB_SEL_RESET = 3'h0;
  localparam logic [15:0] HRP_CNT_RESET = 16'h0000;
  localparam logic [7:0] HRP_CB_DIV_RESET = 8'h00;

  typedef enum logic [1:0] {
    HRP_IDLE = 2'b00,
    HRP_WAIT = 2'b01,
    HRP_RUN = 2'b10,
    HRP_PUSH = 2'b11
  } hrp_state_t;
endpackage

// *** hw/hrp_buf2.sv ***
// two-entry buffer with valid/ready on both sides and registered outputs
`timescale 1ns/1ns
module hrp_buf2 #(
  parameter int WIDTH = 48
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic valid1;
  logic [WIDTH-1:0] data1;
  logic push;
  logic pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // ready only depends on the back slot, so no combinational path from out_ready
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      out_valid <= 1'b0;
      valid1 <= 1'b0;
      in_ready <= 1'b1;
      out_data <= '0;
      data1 <= '0;
    end
    else
    begin
      if (pop)
      begin
        out_valid <= valid1 | push;
        out_data <= valid1 ? data1 : in_data;
        valid1 <= valid1 & push;
        if (valid1 & push)
          data1 <= in_data;
        in_ready <= 1'b1;
      end
      else if (push)
      begin
        if (!out_valid)
        begin
          out_valid <= 1'b1;
          out_data <= in_data;
        end
        else
        begin
          valid1 <= 1'b1;
          data1 <= in_data;
          in_ready <= 1'b0;
        end
      end
    end
  end
endmodule

// *** hw/hrp_port.sv ***
// hardware-response port with serializer, port counter and six clock blocks
`timescale 1ns/1ns
// Summary of operation
// - port width is a parameter: 1, 4, 8, 16 or 32 pins.
// - one direction setting covers every pin of the port.
// - drives pins or samples them, optionally waiting for a pin match.
// - a command is taken in one cycle when the port is idle.
// - open-drain: zero pulls low, one releases; chosen per port.
// - input data passes a serializer and transfer register, then a buffer.
// - a 16-bit port counter can time the transfer.
// - counter readable always; a command may wait for a given count.
// - each transfer captures the counter value as a timestamp.
// - an enabled link on the pins disables the port.
// - a narrower enabled port takes precedence on shared pins.
// - unshared pins stay usable by this wider port.
// - transfers keep nominal width even with pins taken.
// - six clock blocks; block 0 is the 100 MHz reference.
// - blocks 1 to 5 run at their own programmed rate.
// - a block may take its clock from an external 1-bit pin.
// - an external clock may be divided by a programmed value.
// - strobe in qualifies input samples; strobe out marks output data.
// - after reset the port runs from clock block 0.
// - pin events are signalled directly to the scheduler.
module hrp_port
  import hrp_pkg::*;
#(
  parameter int PORT_W = HRP_PORT_W_DEF,
  parameter int XFER_W = HRP_XFER_W_DEF
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [PORT_W-1:0] pin_in,
  output logic [PORT_W-1:0] pin_out,
  output logic [PORT_W-1:0] pin_oe,
  input wire logic strobe_in,
  output logic strobe_out,
  input wire logic ext_clk_pin,
  input wire logic link_enable,
  input wire logic [PORT_W-1:0] narrow_taken,
  input wire logic dir_out,
  input wire logic open_drain,
  input wire logic strobe_in_en,
  input wire logic [2:0] clk_sel,
  input wire logic clk_sel_load,
  input wire logic [HRP_NUM_CB-2:0] cb_use_ext,
  input wire logic [(HRP_NUM_CB-1)*HRP_CB_DIV_W-1:0] cb_div,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [XFER_W-1:0] cmd_data,
  input wire logic cmd_timed,
  input wire logic [15:0] cmd_time,
  input wire logic cmd_cond_en,
  input wire logic [PORT_W-1:0] cmd_cond_val,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [XFER_W-1:0] rsp_data,
  output logic [15:0] rsp_stamp,
  output logic [15:0] port_count,
  output logic [15:0] last_stamp,
  output logic event_pulse
);
  localparam int NBEAT = XFER_W / PORT_W;
  localparam int BEAT_W = $clog2(NBEAT + 1);
  localparam logic [BEAT_W-1:0] LAST_BEAT = BEAT_W'(NBEAT - 1);

  // pin and external clock synchronisers
  logic [PORT_W-1:0] pin_meta;
  logic [PORT_W-1:0] pin_sync;
  logic strobe_meta;
  logic strobe_sync;
  logic ext_meta;
  logic ext_sync;
  logic ext_prev;
  logic ext_edge;

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
      strobe_meta <= 1'b0;
      strobe_sync <= 1'b0;
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end
    else
    begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
      strobe_meta <= strobe_in;
      strobe_sync <= strobe_meta;
      ext_meta <= ext_clk_pin;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  assign ext_edge = ext_sync & ~ext_prev;

  // clock blocks: block 0 ticks every reference cycle
  logic [HRP_NUM_CB-1:0] cb_tick;
  assign cb_tick[0] = 1'b1;

  genvar gi;
  generate
    for (gi = 1; gi < HRP_NUM_CB; gi++)
    begin : g_cb
      logic [HRP_CB_DIV_W-1:0] div_cnt;
      logic [HRP_CB_DIV_W-1:0] div_val;
      logic src_event;
      logic tick;
      assign div_val = cb_div[(gi-1)*HRP_CB_DIV_W +: HRP_CB_DIV_W];
      assign src_event = cb_use_ext[gi-1] ? ext_edge : 1'b1;
      always_ff @(posedge clk_sys or posedge reset)
      begin
        if (reset)
        begin
          div_cnt <= HRP_CB_DIV_RESET;
          tick <= 1'b0;
        end
        else
        begin
          tick <= 1'b0;
          if (src_event)
          begin
            // divide by div_val+1, applied to either source
            if (div_cnt >= div_val)
            begin
              div_cnt <= HRP_CB_DIV_RESET;
              tick <= 1'b1;
            end
            else
              div_cnt <= div_cnt + 1'b1;
          end
        end
      end
      assign cb_tick[gi] = tick;
    end
  endgenerate

  // clock block attachment, block 0 from reset
  logic [2:0] clk_src;
  logic port_tick;

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      clk_src <= HRP_CB_SEL_RESET;
    else if (clk_sel_load && clk_sel < 3'(HRP_NUM_CB))
      clk_src <= clk_sel;
  end

  assign port_tick = cb_tick[clk_src];

  // port counter
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      port_count <= HRP_CNT_RESET;
    else if (port_tick)
      port_count <= port_count + 16'h0001;
  end

  // pin ownership: link first, then narrower ports, then this one
  logic [PORT_W-1:0] usable;
  logic [PORT_W-1:0] in_val;
  assign usable = ~narrow_taken & {PORT_W{~link_enable}};
  // taken pins read as zero so the word keeps its full width
  assign in_val = pin_sync & usable;

  // transfer engine
  hrp_state_t state;
  logic xfer_write;
  logic xfer_timed;
  logic [15:0] xfer_time;
  logic xfer_cond;
  logic [PORT_W-1:0] xfer_cond_val;
  logic [XFER_W-1:0] shreg;
  logic [BEAT_W-1:0] beat;
  logic [PORT_W-1:0] out_val;
  logic time_ok;
  logic cond_met;
  logic start_ok;
  logic sample_ok;
  logic buf_in_ready;
  logic [XFER_W+15:0] buf_out;

  assign time_ok = ~xfer_timed | (port_count == xfer_time);
  assign cond_met = in_val == xfer_cond_val;
  assign start_ok = time_ok & (xfer_write | ~xfer_cond | cond_met);
  assign sample_ok = ~strobe_in_en | strobe_sync;

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      state <= HRP_IDLE;
      cmd_ready <= 1'b1;
      xfer_write <= 1'b0;
      xfer_timed <= 1'b0;
      xfer_time <= HRP_CNT_RESET;
      xfer_cond <= 1'b0;
      xfer_cond_val <= '0;
      shreg <= '0;
      beat <= '0;
    end
    else
    begin
      case (state)
        HRP_IDLE:
        begin
          // single-cycle acceptance while idle
          if (cmd_valid)
          begin
            cmd_ready <= 1'b0;
            xfer_write <= dir_out;
            xfer_timed <= cmd_timed;
            xfer_time <= cmd_time;
            xfer_cond <= cmd_cond_en;
            xfer_cond_val <= cmd_cond_val;
            shreg <= cmd_data;
            beat <= '0;
            state <= HRP_WAIT;
          end
        end
        HRP_WAIT:
        begin
          if (port_tick && start_ok)
            state <= HRP_RUN;
        end
        HRP_RUN:
        begin
          if (port_tick && (xfer_write || sample_ok))
          begin
            // lsb beat first in both directions
            if (!xfer_write)
              shreg <= {in_val, shreg[XFER_W-1:PORT_W]};
            else
              shreg <= shreg >> PORT_W;
            beat <= beat + 1'b1;
            if (beat == LAST_BEAT)
            begin
              if (xfer_write)
              begin
                state <= HRP_IDLE;
                cmd_ready <= 1'b1;
              end
              else
                state <= HRP_PUSH;
            end
          end
        end
        HRP_PUSH:
        begin
          // hold here while the buffer is full; no word is dropped
          if (buf_in_ready)
          begin
            state <= HRP_IDLE;
            cmd_ready <= 1'b1;
          end
        end
        default:
        begin
          state <= HRP_IDLE;
          cmd_ready <= 1'b1;
        end
      endcase
    end
  end

  // timestamp taken at the start of each transfer
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      last_stamp <= HRP_CNT_RESET;
    else if (state == HRP_WAIT && port_tick && start_ok)
      last_stamp <= port_count;
  end

  // scheduler event on a met condition or a completed input word
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      event_pulse <= 1'b0;
    else
      event_pulse <= (state == HRP_WAIT && port_tick && start_ok && xfer_cond && !xfer_write)
        || (state == HRP_PUSH && buf_in_ready);
  end

  // output value register and strobe out
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      out_val <= '0;
      strobe_out <= 1'b0;
    end
    else
    begin
      if (state == HRP_RUN && xfer_write && port_tick)
      begin
        out_val <= shreg[PORT_W-1:0];
        strobe_out <= 1'b1;
      end
      else if (port_tick)
        strobe_out <= 1'b0;
    end
  end

  // pin drivers: open drain only ever pulls low
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      pin_out <= '0;
      pin_oe <= '0;
    end
    else
    begin
      if (open_drain)
      begin
        pin_out <= '0;
        pin_oe <= ~out_val & usable & {PORT_W{dir_out}};
      end
      else
      begin
        pin_out <= out_val;
        pin_oe <= usable & {PORT_W{dir_out}};
      end
    end
  end

  // input words and their stamps wait here for the core
  hrp_buf2 #(
    .WIDTH(XFER_W + 16)
  ) u_buf (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_valid(state == HRP_PUSH),
    .in_ready(buf_in_ready),
    .in_data({last_stamp, shreg}),
    .out_valid(rsp_valid),
    .out_ready(rsp_ready),
    .out_data(buf_out)
  );

  assign rsp_data = buf_out[XFER_W-1:0];
  assign rsp_stamp = buf_out[XFER_W+15:XFER_W];
endmodule

// *** verif/hrp_pin_model.sv ***
// far-side pin hardware: strobed word source and gated external clock
`timescale 1ns/1ns
module hrp_pin_model (
  input wire logic clk_sys,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  input wire logic feed,
  input wire logic [31:0] word,
  input wire logic ext_run,
  output logic [3:0] pin_in,
  output logic strobe_in,
  output logic ext_clk_pin
);
  logic [3:0] drv = 4'h0;
  int ph = 0;
  wire act = ph != 0 || feed;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv);
  // data scrambles between strobes so a stray sample shows up
  // pins rest low between frames, as the pull-downs hold them
  always @(posedge clk_sys)
  begin
    strobe_in <= act && ph % 3 == 1;
    if (act && ph % 3 == 0)
      drv <= word[ph / 3 * 4 +: 4];
    else if (!act)
      drv <= 4'h0;
    else if (ph % 3 == 2)
      drv <= ~drv;
    if (act)
      ph <= (ph == 23) ? 0 : ph + 1;
  end
  // clock stands still while ext_run is low
  initial
  begin
    ext_clk_pin = 1'b0;
    #3;
    forever #80 if (ext_run) ext_clk_pin = ~ext_clk_pin;
  end
endmodule

// *** verif/hrp_port_sva.sv ***
// concurrent checks on the port's pins, handshakes and counters
`timescale 1ns/1ns
module hrp_port_sva
  import hrp_pkg::*;
#(
  parameter int PORT_W = HRP_PORT_W_DEF,
  parameter int XFER_W = HRP_XFER_W_DEF
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [PORT_W-1:0] pin_out,
  input wire logic [PORT_W-1:0] pin_oe,
  input wire logic link_enable,
  input wire logic [PORT_W-1:0] narrow_taken,
  input wire logic open_drain,
  input wire logic [2:0] clk_sel,
  input wire logic clk_sel_load,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire logic [XFER_W-1:0] rsp_data,
  input wire logic [15:0] port_count,
  input wire logic [15:0] last_stamp
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  logic [2:0] sel;
  logic [2:0] age;
  // pacing trusted only once a selection has settled
  always_ff @(posedge clk_sys or posedge reset)
    if (reset)
    begin
      sel <= 3'h0;
      age <= 3'h0;
    end
    else if (clk_sel_load && clk_sel < 3'h6)
    begin
      sel <= clk_sel;
      age <= 3'h0;
    end
    else if (age != 3'h4)
      age <= age + 3'h1;
  a_link_off: assert property (link_enable [*3] |-> pin_oe == '0)
    else $error("pins driven under link");
  a_narrow_off: assert property ((pin_oe & narrow_taken & $past(narrow_taken, 2)) == '0)
    else $error("taken pin driven");
  a_od_low: assert property (open_drain [*3] |-> pin_out == '0)
    else $error("open drain drove high");
  a_take_busy: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
    else $error("ready held after take");
  a_cnt_step: assert property ($changed(port_count) |->
    port_count == $past(port_count) + 16'h1) else $error("counter jumped");
  a_ref_rate: assert property (sel == 3'h0 && age == 3'h4 |->
    port_count == $past(port_count) + 16'h1) else $error("block 0 missed a tick");
  a_stamp_hold: assert property ($changed(last_stamp) |-> !$past(cmd_ready))
    else $error("stamp moved while idle");
  a_rsp_hold: assert property (rsp_valid && !rsp_ready |=>
    rsp_valid && $stable(rsp_data)) else $error("response lost in stall");
  c_take: cover property (cmd_valid && cmd_ready);
  c_stall: cover property (rsp_valid && !rsp_ready);
  c_link: cover property (link_enable [*3]);
endmodule
bind hrp_port hrp_port_sva #(.PORT_W(PORT_W), .XFER_W(XFER_W)) hrp_port_sva_inst (.clk_sys,
  .reset, .pin_out, .pin_oe, .link_enable, .narrow_taken, .open_drain, .clk_sel,
  .clk_sel_load, .cmd_valid, .cmd_ready, .rsp_valid, .rsp_ready, .rsp_data, .port_count,
  .last_stamp);

// *** verif/tb.sv ***
// self-checking bench for the hardware-response port
`timescale 1ns/1ns
module tb;
  import hrp_pkg::*;
  logic clk_sys, reset, strobe_in, strobe_out, ext_clk_pin, link_enable, dir_out, open_drain;
  logic strobe_in_en, clk_sel_load, cmd_valid, cmd_ready, cmd_timed, cmd_cond_en, rsp_valid;
  logic rsp_ready, event_pulse, feed, ext_run;
  logic [3:0] pin_in, pin_out, pin_oe, narrow_taken, cmd_cond_val;
  logic [2:0] clk_sel;
  logic [4:0] cb_use_ext;
  logic [39:0] cb_div;
  logic [31:0] cmd_data, rsp_data, word;
  logic [15:0] cmd_time, rsp_stamp, port_count, last_stamp;
  int err_total = 0, n_tests = 0, cyc = 0, n_ev = 0;
  hrp_port hrp_port_inst (.clk_sys, .reset, .pin_in, .pin_out, .pin_oe, .strobe_in, .strobe_out,
    .ext_clk_pin, .link_enable, .narrow_taken, .dir_out, .open_drain, .strobe_in_en, .clk_sel,
    .clk_sel_load, .cb_use_ext, .cb_div, .cmd_valid, .cmd_ready, .cmd_data, .cmd_timed,
    .cmd_time, .cmd_cond_en, .cmd_cond_val, .rsp_valid, .rsp_ready, .rsp_data, .rsp_stamp,
    .port_count, .last_stamp, .event_pulse);
  hrp_pin_model hrp_pin_model_inst (.clk_sys, .pin_out, .pin_oe, .feed, .word, .ext_run,
    .pin_in, .strobe_in, .ext_clk_pin);
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // outputs are read at the falling edge, where they have settled
  always @(negedge clk_sys)
  begin
    cyc++;
    n_ev += (event_pulse === 1'b1);
    if (cyc == 5000)
    begin
      err_total++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wait_for(ref logic s);
    for (int n = 0; n < 200 && s !== 1'b1; n++)
      @(negedge clk_sys);
  endtask
  task automatic issue(logic d, logic [31:0] w, logic tm, logic [15:0] t);
    wait_for(cmd_ready);
    chk("command ready", 1, cmd_ready);
    {dir_out, cmd_data, cmd_timed, cmd_time, cmd_valid} = {d, w, tm, t, 1'b1};
    @(negedge clk_sys);
    cmd_valid = 1'b0;
  endtask
  task automatic out_word(logic od, logic [3:0] tk, logic tm);
    logic [31:0] w;
    logic [15:0] t;
    {open_drain, narrow_taken} = {od, tk};
    t = port_count + 16'h28;
    issue(1'b1, 32'h9e3c5a71, tm, t);
    // pins trail the strobe by one cycle
    wait_for(strobe_out);
    for (int b = 0; b < 8; b++)
    begin
      @(negedge clk_sys);
      w[b * 4 +: 4] = od ? ~pin_oe : pin_out;
      // strobe drops at the tick after the last beat
      chk("strobe out", 32'(b < 7), strobe_out);
      if (od)
        chk("drain level", 0, pin_out);
    end
    chk("output word", 32'h9e3c5a71 | {8{tk}}, w);
    if (tm)
      chk("start stamp", t, last_stamp);
  endtask
  task automatic link_off();
    chk("pins held", 4'hf, pin_oe);
    link_enable = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("pins under link", 0, pin_oe);
    link_enable = 1'b0;
  endtask
  task automatic in_words();
    logic [15:0] st [3];
    {open_drain, narrow_taken, strobe_in_en} = {1'b0, 4'h0, 1'b1};
    for (int k = 0; k < 3; k++)
    begin
      issue(1'b0, 32'h0, 1'b0, 16'h0);
      // block 0: the start tick follows the take, so the stamp is this count
      st[k] = port_count;
      chk("input pins released", 0, pin_oe);
      word = 32'h5a0f1e2d + 32'h11111111 * k;
      feed = 1'b1;
      @(negedge clk_sys);
      feed = 1'b0;
      repeat (40) @(negedge clk_sys);
    end
    // third word has nowhere to go until the reader drains
    chk("held in push", 0, cmd_ready);
    rsp_ready = 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      wait_for(rsp_valid);
      chk("input word", 32'h5a0f1e2d + 32'h11111111 * k, rsp_data);
      chk("input stamp", st[k], rsp_stamp);
      @(negedge clk_sys);
    end
    chk("word events", 3, n_ev);
  endtask
  task automatic cond_in();
    int e;
    logic [15:0] c;
    {cmd_cond_en, cmd_cond_val} = {1'b1, 4'h6};
    issue(1'b0, 32'h0, 1'b0, 16'h0);
    e = n_ev;
    repeat (10) @(negedge clk_sys);
    chk("cond holds off", e, n_ev);
    c = port_count;
    word = 32'hc3a5f096;
    feed = 1'b1;
    @(negedge clk_sys);
    feed = 1'b0;
    wait_for(rsp_valid);
    chk("cond word", 32'hc3a5f096, rsp_data);
    // one cycle to the pin, then two sync stages before the match
    chk("cond stamp", c + 16'h3, rsp_stamp);
    @(negedge clk_sys);
    chk("cond events", e + 2, n_ev);
    cmd_cond_en = 1'b0;
  endtask
  task automatic ext_clock();
    logic [15:0] c;
    logic [2:0] sel_tab [4] = '{3'h1, 3'h1, 3'h6, 3'h0};
    int exp_tab [4] = '{10, 5, 0, 20};
    cb_use_ext = 5'h01;
    for (int s = 0; s < 4; s++)
    begin
      {cb_div, clk_sel, clk_sel_load} = {32'h0, 8'(s % 2), sel_tab[s], 1'b1};
      @(negedge clk_sys);
      clk_sel_load = 1'b0;
      repeat (4) @(negedge clk_sys);
      c = port_count;
      if (s < 2)
      begin
        ext_run = 1'b1;
        repeat (10) @(posedge ext_clk_pin);
        ext_run = 1'b0;
        repeat (6) @(negedge clk_sys);
      end
      else
        repeat (20) @(negedge clk_sys);
      chk("block ticks", exp_tab[s], port_count - c);
    end
  endtask
  initial
  begin
    reset = 1'b1;
    {link_enable, narrow_taken, dir_out, open_drain, strobe_in_en, clk_sel, clk_sel_load} = '0;
    {cb_use_ext, cb_div, cmd_valid, cmd_data, cmd_timed, cmd_time, cmd_cond_en} = '0;
    {cmd_cond_val, rsp_ready, feed, ext_run, word} = '0;
    repeat (10) @(negedge clk_sys);
    reset = 1'b0;
    chk("ready at reset", 1, cmd_ready);
    chk("stamp at reset", 0, last_stamp);
    out_word(1'b0, 4'h0, 1'b0);
    link_off();
    out_word(1'b1, 4'h1, 1'b1);
    in_words();
    cond_in();
    ext_clock();
    print_verdict();
  end
endmodule
